/* File: common/ext_space_pkg.sv */
package ext_space_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int NUM_SPACES = 8;
  localparam logic [2:0] AREA0_IDX = 3'h0;
  localparam logic [2:0] AREA5B_IDX = 3'h5;
  localparam logic [7:0] BCR_BASE = 8'h00;
  localparam logic [7:0] WCR_BASE = 8'h20;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int TYPE_LSB = 12;
  localparam int WIDTH_LSB = 9;
  localparam int SETUP_LSB = 11;
  localparam int WBA_BIT = 13;
  localparam logic [2:0] TYPE_RESET = 3'h0;
  localparam logic [1:0] WIDTH_RESET = 2'h3;
  localparam logic [31:0] WCR_RESET = 32'h00000500;
  localparam logic [1:0] BOOT_SYNC_CYCLES = 2'h2;

  typedef enum logic [2:0] {
    MT_NORMAL = 3'h0,
    MT_BURST_ROM = 3'h1,
    MT_MPX_IO = 3'h2,
    MT_BYTE_SRAM = 3'h3,
    MT_SDRAM = 3'h4,
    MT_PROHIBITED = 3'h5,
    MT_BURST_MPX = 3'h6,
    MT_BURST_ROM2 = 3'h7
  } mem_type_e;

  localparam logic [1:0] WIDTH_RSVD = 2'h0;
  localparam logic [1:0] WIDTH_8 = 2'h1;
  localparam logic [1:0] WIDTH_16 = 2'h2;
  localparam logic [1:0] WIDTH_32 = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SETUP = 3'b010,
    ST_STROBE = 3'b100
  } acc_state_e;

  typedef struct packed {
    logic [2:0] area;
    logic addr_sel;
  } acc_req_s;

endpackage

/* File: hdl/ext_space_width_setup_cfg.sv */
`timescale 1ns/1ps

// Function
// - Width code 01, 10, 11 gives 8, 16, 32 bits for areas 2, 3, 4 and 5A; 00 is reserved.
// - Area 5B as multiplexed I/O with width 11 picks 8 or 16 bits per access from the address.
// - Area 0 width comes from the boot pin and writes to its width field are ignored.
// - Bus control bits 8 to 0 read as zero and software writes zero there.
// - At power-on reset the area 0 width is latched from the boot width pin.
// - The wait control layout depends on the memory type of the same space.
// - Wait control loads 0x00000500 at power-on reset and survives manual reset.
// - Setup code 00 to 11 delays the strobe by 0.5 to 3.5 cycles after chip select.
// - The memory type field selects the space kind and code 101 is prohibited.
module ext_space_width_setup_cfg (
  // Clock and power-on reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pins
  input wire logic boot_width_pin_i,
  input wire logic manual_rst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Access request
  input wire logic acc_start_i,
  input wire logic acc_end_i,
  input wire ext_space_pkg::acc_req_s acc_req_i,
  // Bus side
  output logic chip_select_n_o,
  output logic strobe_n_o,
  output logic [1:0] bus_width_o,
  output logic width_invalid_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers and boot width capture
  // ----------------------------------------------------------------
  logic boot_s1_reg, boot_s2_reg, mrst_s1_reg, mrst_s2_reg;
  logic [1:0] cap_cnt_reg, cap_cnt_next;
  logic boot_done_reg, boot_done_next;
  logic [1:0] boot_width_reg, boot_width_next;

  always_comb begin
    cap_cnt_next = cap_cnt_reg;
    boot_done_next = boot_done_reg;
    boot_width_next = boot_width_reg;
    if (!boot_done_reg) begin
      if (cap_cnt_reg == ext_space_pkg::BOOT_SYNC_CYCLES) begin
        boot_done_next = 1'b1;
        boot_width_next = boot_s2_reg ? ext_space_pkg::WIDTH_32 : ext_space_pkg::WIDTH_16;
      end else begin
        cap_cnt_next = cap_cnt_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      boot_s1_reg <= 1'b0;
      boot_s2_reg <= 1'b0;
      mrst_s1_reg <= 1'b0;
      mrst_s2_reg <= 1'b0;
      cap_cnt_reg <= 2'h0;
      boot_done_reg <= 1'b0;
      boot_width_reg <= ext_space_pkg::WIDTH_RESET;
    end else begin
      boot_s1_reg <= boot_width_pin_i;
      boot_s2_reg <= boot_s1_reg;
      mrst_s1_reg <= manual_rst_i;
      mrst_s2_reg <= mrst_s1_reg;
      cap_cnt_reg <= cap_cnt_next;
      boot_done_reg <= boot_done_next;
      boot_width_reg <= boot_width_next;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Only the power-on reset touches these; a manual reset leaves them alone.
  logic [2:0] type_reg [ext_space_pkg::NUM_SPACES];
  logic [1:0] width_reg [ext_space_pkg::NUM_SPACES];
  logic [31:0] wcr_reg [ext_space_pkg::NUM_SPACES];
  logic [31:0] rdata_reg, rdata_next;
  logic [31:0] bcr_view [ext_space_pkg::NUM_SPACES];

  genvar g;
  generate
    for (g = 0; g < ext_space_pkg::NUM_SPACES; g++) begin : g_space
      logic [2:0] type_next;
      logic [1:0] width_next;
      logic [31:0] wcr_next;
      logic bcr_hit, wcr_hit;
      assign bcr_hit = reg_wr_i && (reg_addr_i == ext_space_pkg::BCR_BASE + 8'(4 * g));
      assign wcr_hit = reg_wr_i && (reg_addr_i == ext_space_pkg::WCR_BASE + 8'(4 * g));
      always_comb begin
        type_next = type_reg[g];
        width_next = width_reg[g];
        wcr_next = wcr_reg[g];
        if (bcr_hit) begin
          type_next = reg_wdata_i[ext_space_pkg::TYPE_LSB +: 3];
          if (g != 0) begin
            width_next = reg_wdata_i[ext_space_pkg::WIDTH_LSB +: 2];
          end
        end
        if (wcr_hit) begin
          wcr_next = reg_wdata_i;
        end
      end
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          type_reg[g] <= ext_space_pkg::TYPE_RESET;
          width_reg[g] <= ext_space_pkg::WIDTH_RESET;
          wcr_reg[g] <= ext_space_pkg::WCR_RESET;
        end else begin
          type_reg[g] <= type_next;
          width_reg[g] <= width_next;
          wcr_reg[g] <= wcr_next;
        end
      end
      always_comb begin
        bcr_view[g] = 32'h00000000;
        bcr_view[g][ext_space_pkg::TYPE_LSB +: 3] = type_reg[g];
        bcr_view[g][ext_space_pkg::WIDTH_LSB +: 2] = (g == 0) ? boot_width_reg : width_reg[g];
      end
    end
  endgenerate

  always_comb begin
    rdata_next = 32'h00000000;
    if (reg_rd_i) begin
      for (int i = 0; i < ext_space_pkg::NUM_SPACES; i++) begin
        if (reg_addr_i == ext_space_pkg::BCR_BASE + 8'(4 * i)) begin
          rdata_next = bcr_view[i];
        end
        if (reg_addr_i == ext_space_pkg::WCR_BASE + 8'(4 * i)) begin
          rdata_next = wcr_reg[i];
        end
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h00000000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_o = rdata_reg;

  // ----------------------------------------------------------------
  // Access sequencing
  // ----------------------------------------------------------------
  ext_space_pkg::acc_state_e state_reg, state_next;
  ext_space_pkg::acc_req_s req_reg, req_next;
  logic [1:0] cnt_reg, cnt_next;
  logic [1:0] out_width_reg, out_width_next;
  logic strobe_due;
  logic [1:0] setup_code;
  logic [1:0] eff_width;
  ext_space_pkg::mem_type_e cur_type;

  // The setup field only exists in the layouts that carry it; other types strobe at once.
  always_comb begin
    cur_type = ext_space_pkg::mem_type_e'(type_reg[acc_req_i.area]);
    setup_code = 2'h0;
    if (cur_type == ext_space_pkg::MT_NORMAL || cur_type == ext_space_pkg::MT_BYTE_SRAM ||
        cur_type == ext_space_pkg::MT_MPX_IO) begin
      setup_code = wcr_reg[acc_req_i.area][ext_space_pkg::SETUP_LSB +: 2];
    end
  end

  always_comb begin
    eff_width = width_reg[acc_req_i.area];
    if (acc_req_i.area == ext_space_pkg::AREA0_IDX) begin
      eff_width = boot_width_reg;
    end else if (acc_req_i.area == ext_space_pkg::AREA5B_IDX && cur_type == ext_space_pkg::MT_MPX_IO &&
                 width_reg[acc_req_i.area] == ext_space_pkg::WIDTH_32) begin
      eff_width = ext_space_pkg::WIDTH_16;
      if (wcr_reg[acc_req_i.area][ext_space_pkg::WBA_BIT] && !acc_req_i.addr_sel) begin
        eff_width = ext_space_pkg::WIDTH_8;
      end
    end
  end

  always_comb begin
    state_next = state_reg;
    req_next = req_reg;
    cnt_next = cnt_reg;
    out_width_next = out_width_reg;
    case (state_reg)
      ext_space_pkg::ST_IDLE: begin
        if (acc_start_i && !mrst_s2_reg) begin
          state_next = ext_space_pkg::ST_SETUP;
          req_next = acc_req_i;
          cnt_next = setup_code;
          out_width_next = eff_width;
        end
      end
      ext_space_pkg::ST_SETUP: begin
        if (cnt_reg == 2'h0) begin
          state_next = ext_space_pkg::ST_STROBE;
        end else begin
          cnt_next = cnt_reg - 2'h1;
        end
      end
      ext_space_pkg::ST_STROBE: begin
        if (acc_end_i) begin
          state_next = ext_space_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = ext_space_pkg::ST_IDLE;
      end
    endcase
    if (mrst_s2_reg || (acc_end_i && state_reg != ext_space_pkg::ST_IDLE)) begin
      state_next = ext_space_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ext_space_pkg::ST_IDLE;
      req_reg <= '0;
      cnt_reg <= 2'h0;
      out_width_reg <= ext_space_pkg::WIDTH_RSVD;
    end else begin
      state_reg <= state_next;
      req_reg <= req_next;
      cnt_reg <= cnt_next;
      out_width_reg <= out_width_next;
    end
  end

  assign strobe_due = (state_reg == ext_space_pkg::ST_STROBE) ||
                      (state_reg == ext_space_pkg::ST_SETUP && cnt_reg == 2'h0);

  // Sampling on the falling edge puts the strobe half a cycle after the setup count reaches zero.
  logic strobe_n_reg;
  always_ff @(negedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      strobe_n_reg <= 1'b1;
    end else begin
      strobe_n_reg <= !strobe_due;
    end
  end

  assign strobe_n_o = strobe_n_reg;
  assign chip_select_n_o = (state_reg == ext_space_pkg::ST_IDLE);
  assign bus_width_o = out_width_reg;
  assign width_invalid_o = (out_width_reg == ext_space_pkg::WIDTH_RSVD) && !chip_select_n_o;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [2:0] since_cs_reg;
  logic [1:0] code_seen_reg;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      since_cs_reg <= 3'h0;
      code_seen_reg <= 2'h0;
    end else if (state_reg == ext_space_pkg::ST_IDLE) begin
      since_cs_reg <= 3'h0;
      code_seen_reg <= setup_code;
    end else if (since_cs_reg != 3'h7) begin
      since_cs_reg <= since_cs_reg + 3'h1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_start;
    state_reg == ext_space_pkg::ST_IDLE && acc_start_i && !mrst_s2_reg;
  endsequence

  property p_width_plain;
    s_start and (acc_req_i.area inside {3'h1, 3'h2, 3'h3, 3'h4}) |=> bus_width_o == $past(width_reg[acc_req_i.area]);
  endproperty
  a_width_plain: assert property (p_width_plain) else $error("plain area width wrong");

  property p_mpx5b;
    s_start and (acc_req_i.area == ext_space_pkg::AREA5B_IDX && cur_type == ext_space_pkg::MT_MPX_IO &&
      width_reg[ext_space_pkg::AREA5B_IDX] == ext_space_pkg::WIDTH_32) |=> bus_width_o != ext_space_pkg::WIDTH_32;
  endproperty
  a_mpx5b: assert property (p_mpx5b) else $error("area 5B mpx width not 8 or 16");

  property p_area0;
    s_start and (acc_req_i.area == ext_space_pkg::AREA0_IDX) |=> bus_width_o == boot_width_reg;
  endproperty
  a_area0: assert property (p_area0) else $error("area 0 width not from boot pin");

  property p_rsvd_zero;
    reg_rd_i && reg_addr_i < ext_space_pkg::WCR_BASE |=> reg_rdata_o[8:0] == 9'h000;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bus control bits nonzero");

  property p_boot_latch;
    $rose(boot_done_reg) |-> boot_width_reg == ($past(boot_s2_reg) ? ext_space_pkg::WIDTH_32 : ext_space_pkg::WIDTH_16);
  endproperty
  a_boot_latch: assert property (p_boot_latch) else $error("boot width not latched");

  property p_no_setup_type;
    s_start and (cur_type == ext_space_pkg::MT_SDRAM) |=> strobe_due;
  endproperty
  a_no_setup_type: assert property (p_no_setup_type) else $error("setup used outside its layout");

  property p_manual_keep;
    mrst_s2_reg && !reg_wr_i |=> $stable(wcr_reg[0]) && $stable(wcr_reg[5]);
  endproperty
  a_manual_keep: assert property (p_manual_keep) else $error("wait control lost on manual reset");

  property p_setup_delay;
    $rose(strobe_due) |-> since_cs_reg == {1'b0, code_seen_reg};
  endproperty
  a_setup_delay: assert property (p_setup_delay) else $error("setup delay count wrong");

  property p_half_cycle;
    strobe_n_o == !strobe_due;
  endproperty
  a_half_cycle: assert property (p_half_cycle) else $error("strobe not on falling edge");

endmodule

/* File: sim/ext_mem_model.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Far-side memory model
// ----------------------------------------------------------------
module ext_mem_model #(
  parameter real HALF_NS = 25.0
) (
  // Bus side
  input wire logic chip_select_n_i,
  input wire logic strobe_n_i,
  // Measurement
  output logic strobe_seen_o,
  output logic [3:0] setup_halves_o
);
  realtime t_cs;

  initial begin
    strobe_seen_o = 1'b0;
    setup_halves_o = 4'h0;
    t_cs = 0;
  end

  // The select edge starts the count; whole half periods show which clock edge drove the strobe.
  always @(negedge chip_select_n_i) begin
    t_cs = $realtime;
    strobe_seen_o = 1'b0;
  end

  always @(negedge strobe_n_i) begin
    setup_halves_o = 4'(int'(($realtime - t_cs) / HALF_NS));
    strobe_seen_o = 1'b1;
  end
endmodule

/* File: sim/ext_space_width_setup_cfg_bench.sv */
`timescale 1ns/1ps

module ext_space_width_setup_cfg_bench;
  logic clk_i, rst_i, boot_width_pin_i, manual_rst_i, reg_wr_i, reg_rd_i, acc_start_i, acc_end_i;
  logic [7:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, rs, v;
  ext_space_pkg::acc_req_s acc_req_i;
  logic chip_select_n_o, strobe_n_o, width_invalid_o, seen;
  logic [1:0] bus_width_o;
  logic [3:0] halves;
  logic [2:0] ty;
  int n_fail, comparisons;

  ext_space_width_setup_cfg dut_u (.clk_i(clk_i), .rst_i(rst_i), .boot_width_pin_i(boot_width_pin_i),
    .manual_rst_i(manual_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .acc_start_i(acc_start_i), .acc_end_i(acc_end_i),
    .acc_req_i(acc_req_i), .chip_select_n_o(chip_select_n_o), .strobe_n_o(strobe_n_o),
    .bus_width_o(bus_width_o), .width_invalid_o(width_invalid_o));

  ext_mem_model mem_u (.chip_select_n_i(chip_select_n_o), .strobe_n_i(strobe_n_o),
    .strobe_seen_o(seen), .setup_halves_o(halves));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  // Only the type and width fields survive; area 0 width follows the boot pin.
  function automatic logic [31:0] bcr_exp(input logic [2:0] a, input logic [2:0] t, input logic [1:0] w);
    return {17'h0, t, 1'b0, (a == 3'h0) ? {1'b1, boot_width_pin_i} : w, 9'h0};
  endfunction

  function automatic logic [7:0] bcr(input logic [2:0] a);
    return ext_space_pkg::BCR_BASE + {3'h0, a, 2'h0};
  endfunction

  function automatic logic [7:0] wcr(input logic [2:0] a);
    return ext_space_pkg::WCR_BASE + {3'h0, a, 2'h0};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_i);
    check(reg_rdata_o, exp);
    @(posedge clk_i);
  endtask

  task automatic acc(input logic [2:0] a, input logic sel, input logic [1:0] w, input logic [3:0] h);
    int i;
    acc_req_i <= ext_space_pkg::acc_req_s'({a, sel});
    acc_start_i <= 1'b1;
    @(posedge clk_i);
    acc_start_i <= 1'b0;
    for (i = 0; i < 12; i++) begin
      @(posedge clk_i);
      if (seen === 1'b1) break;
    end
    if (i == 12) begin
      n_fail++;
      results();
    end
    check(chip_select_n_o, 0);
    check(bus_width_o, w);
    check(width_invalid_o, 0);
    check(halves, h);
    acc_end_i <= 1'b1;
    @(posedge clk_i);
    acc_end_i <= 1'b0;
    for (i = 0; i < 8 && chip_select_n_o !== 1'b1; i++) @(posedge clk_i);
    if (chip_select_n_o !== 1'b1) begin
      n_fail++;
      results();
    end
    @(posedge clk_i);
  endtask

  // Bus control is always written before wait control of the same area.
  task automatic setup(input logic [2:0] a, input logic [2:0] t, input logic [1:0] w, input logic [31:0] wc);
    wr(bcr(a), {17'h0, t, 1'b0, w, 9'h0});
    wr(wcr(a), wc);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rs = 32'd59148;
    {rst_i, boot_width_pin_i, manual_rst_i, reg_wr_i, reg_rd_i, acc_start_i, acc_end_i} = 7'b1000000;
    reg_addr_i = 8'h00;
    reg_wdata_i = 32'h0;
    acc_req_i = '0;
    n_fail = 0;
    comparisons = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      rd(bcr(3'(i)), bcr_exp(3'(i), 3'h0, 2'h3));
      rd(wcr(3'(i)), ext_space_pkg::WCR_RESET);
    end
    $display("test reset values done");
    for (int i = 0; i < 16; i++) begin
      v = rnd();
      ty = (v[14:12] == 3'h5) ? 3'h4 : v[14:12];
      if (v[10:9] == 2'h0) v[10:9] = 2'h1;
      if (ty == 3'h4 && v[10:9] == 2'h1) v[10:9] = 2'h2;
      if (ty == 3'h6) v[10:9] = 2'h3;
      wr(bcr(v[18:16]), {v[31:15], ty, v[11:9], 9'h000});
      rd(bcr(v[18:16]), bcr_exp(v[18:16], ty, v[10:9]));
      v = rnd();
      if (v[22:20] == 3'h0) v[31:13] = 19'h0;
      wr(wcr(v[22:20]), v);
      rd(wcr(v[22:20]), v);
    end
    $display("test register fields done");
    for (int k = 0; k < 4; k++) begin
      setup(3'h3, 3'h0, 2'(1 + k % 3), {19'h0, 2'(k), 11'h0});
      acc(3'h3, 1'b0, 2'(1 + k % 3), 4'(2 * k + 1));
    end
    setup(3'h1, 3'h4, 2'h2, 32'h00001800);
    acc(3'h1, 1'b0, 2'h2, 4'h1);
    setup(3'h2, 3'h4, 2'h3, 32'h00001800);
    acc(3'h2, 1'b0, 2'h3, 4'h1);
    setup(3'h4, 3'h3, 2'h1, 32'h00001000);
    acc(3'h4, 1'b0, 2'h1, 4'h5);
    setup(3'h6, 3'h6, 2'h3, 32'h0);
    acc(3'h6, 1'b1, 2'h3, 4'h1);
    $display("test access setup done");
    setup(3'h5, 3'h2, 2'h3, 32'h00002000);
    acc(3'h5, 1'b0, 2'h1, 4'h1);
    acc(3'h5, 1'b1, 2'h2, 4'h1);
    wr(wcr(3'h5), 32'h0);
    acc(3'h5, 1'b0, 2'h2, 4'h1);
    setup(3'h0, 3'h0, 2'h1, 32'h0);
    acc(3'h0, 1'b0, 2'h2, 4'h1);
    $display("test width select done");
    v = rnd();
    wr(wcr(3'h7), v);
    manual_rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    manual_rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd(wcr(3'h7), v);
    {rst_i, boot_width_pin_i} <= 2'b11;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(wcr(3'h7), ext_space_pkg::WCR_RESET);
    rd(bcr(3'h0), 32'h00000600);
    acc(3'h0, 1'b0, 2'h3, 4'h1);
    $display("test resets done");
    results();
  end
endmodule
